//--- rscd_pkg.sv
/*
 * rscd_pkg: command codes, field positions and sizes
 * for the radio spi command decoder.
 * assumes: used by the decoder top, its event cdc module and the bench.
 */
`default_nettype none
package rscd_pkg;
    localparam logic [1:0] CMD_REG_RD_TOP   = 2'h0;
    localparam logic [1:0] CMD_REG_WR_TOP   = 2'h1;
    localparam logic [7:0] CMD_RX_READ      = 8'h80;
    localparam logic [2:0] CMD_TX_WRITE_TOP = 3'h5;
    localparam logic [3:0] CMD_ACK_WRITE_TOP = 4'he;
    localparam logic [7:0] CMD_REUSE_TX     = 8'hd0;
    localparam logic [7:0] CMD_FLUSH_TX     = 8'hc5;
    localparam logic [7:0] CMD_FLUSH_RX     = 8'hc4;
    localparam logic [7:0] STATUS_ONLY_CMD  = 8'hff;
    localparam int         TX_POWER_BIT     = 4;
    localparam int         ACK_POWER_BIT    = 3;
    localparam logic [3:0] PIPE_MAX        = 4'h8;
    localparam logic [5:0] PAYLOAD_MAX      = 6'h20;
    localparam logic [5:0] PAYLOAD_MIN      = 6'h01;
    localparam logic [5:0] STATUS_ADDR      = 6'h01;
    localparam logic [5:0] RX_CFG_ADDR      = 6'h1f;
    localparam logic [7:0] STATUS_RESET     = 8'h02;

    typedef enum logic [2:0]
    {
        PH_CMD     = 3'b000,
        PH_REG_RD  = 3'b001,
        PH_REG_WR  = 3'b010,
        PH_RX_HDR  = 3'b011,
        PH_RX_LEN  = 3'b100,
        PH_RX_DATA = 3'b101,
        PH_CHAN    = 3'b110,
        PH_TX_DATA = 3'b111
    } rscd_phase_t;

    // one completed byte or command event passed to the system clock domain
    typedef struct packed
    {
        logic [2:0] kind;
        logic [5:0] addr;
        logic [7:0] data;
        logic       power0;
        logic [3:0] pipe;
    } rscd_evt_t;

    localparam logic [2:0] EV_REG_WR  = 3'h1;
    localparam logic [2:0] EV_TX_BYTE = 3'h2;
    localparam logic [2:0] EV_TX_CHAN = 3'h3;
    localparam logic [2:0] EV_REUSE   = 3'h4;
    localparam logic [2:0] EV_FLUSH_TX = 3'h5;
    localparam logic [2:0] EV_FLUSH_RX = 3'h6;
    localparam logic [2:0] EV_ABORT   = 3'h7;
    localparam logic [2:0] EV_RX_POP  = 3'h0;
endpackage
`default_nettype wire

//--- rscd_sync.sv
/*
 * rscd_sync: two flip-flop level synchroniser.
 * assumes: the input changes slowly relative to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rscd_sync
(
    // clocking
    input  wire logic clock,
    input  wire logic rst_b,
    // level
    input  wire logic dIn,
    output logic      dOut
);
    logic stage1_reg;
    logic stage2_reg;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= dIn;
            stage2_reg <= stage1_reg;
        end
    end
    assign dOut = stage2_reg;
endmodule
`default_nettype wire

//--- rscd_evt_cdc.sv
/*
 * rscd_evt_cdc: toggle handshake carrying one event word from the link
 * clock to the system clock.
 * assumes: source sends at most one event per byte, far slower than the
 * round trip of the handshake.
 */
`timescale 1ns/1ps
`default_nettype none
module rscd_evt_cdc
    import rscd_pkg::*;
(
    // source side, link clock
    input  wire logic      srcClock,
    input  wire logic      srcRst_b,
    input  wire logic      srcValid,
    input  wire rscd_evt_t srcEvt,
    // sink side, system clock
    input  wire logic      clock,
    input  wire logic      rst_b,
    output logic           dstValid,
    output rscd_evt_t      dstEvt
);
    logic      srcTog_reg;
    rscd_evt_t hold_reg;
    logic      dstTog;
    logic      dstSeen_reg;
    always_ff @(posedge srcClock or negedge srcRst_b)
    begin
        if (!srcRst_b)
        begin
            srcTog_reg <= 1'b0;
            hold_reg   <= '0;
        end
        else if (srcValid)
        begin
            srcTog_reg <= ~srcTog_reg;
            hold_reg   <= srcEvt;
        end
    end
    rscd_sync uSync
    (
        .clock (clock),
        .rst_b (rst_b),
        .dIn   (srcTog_reg),
        .dOut  (dstTog)
    );
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            dstSeen_reg <= 1'b0;
        else
            dstSeen_reg <= dstTog;
    end
    // hold word loads with the toggle, so it is stable while the toggle crosses the two sync flops
    assign dstValid = dstTog ^ dstSeen_reg;
    assign dstEvt   = hold_reg;
endmodule
`default_nettype wire

//--- rscd_top.sv
/*
 * rscd_top: spi slave command decoder of a packet radio.
 * assumes: sck idles low, mode 0 (sample on rising, shift on falling);
 * the register file, fifos and radio sit outside; actions leave on plain
 * ports in the clock domain, read data comes in on the link clock view; sck only runs inside a frame.
 */
`timescale 1ns/1ps
`default_nettype none
module rscd_top
    import rscd_pkg::*;
#(
    parameter int PAYLOAD_BYTES = 32
)
(
    // system clock
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       clockEnable,
    // spi link
    input  wire logic       spiSck,
    input  wire logic       chip_select_n,
    input  wire logic       spiMosi,
    output logic            spiMiso,
    output logic            spiMisoOe,
    // register file, link clock view
    input  wire logic [7:0] statusByte,
    input  wire logic [7:0] regReadData,
    // received packet and tx block free flag, link clock view
    input  wire logic [3:0] rxPktRssi,
    input  wire logic [3:0] rxPktPipe,
    input  wire logic [5:0] rxPktLen,
    input  wire logic [7:0] rxPktByte,
    input  wire logic       txBlockFree,
    // actions in the system clock domain
    output logic            regWrite,
    output logic [5:0]      regAddr,
    output logic [7:0]      regWriteData,
    output logic            txPush,
    output logic [7:0]      txByte,
    output logic            txAbort,
    output logic            txStart,
    output logic            txAckPayload,
    output logic [3:0]      txPipe,
    output logic            txForce0dbm,
    output logic [6:0]      txChannel,
    output logic            txReuse,
    output logic            flushTx,
    output logic            flushRx,
    output logic            rxPop,
    output logic [5:0]      rxPayloadIndex
);
    // link-domain state, then system-domain state
    typedef struct packed
    {
        rscd_phase_t phase;
        logic [2:0]  bitCnt;
        logic [7:0]  shiftIn;
        logic [7:0]  cmd;
        logic [5:0]  count;
        logic [5:0]  length;
        logic        ackWrite;
        logic        dead;
    } rscd_rx_t;
    typedef struct packed
    {
        logic [7:0] shiftOut;
        logic       oe;
    } rscd_tx_t;
    typedef struct packed
    {
        logic        regWrite;
        logic [5:0]  regAddr;
        logic [7:0]  regWriteData;
        logic        txPush;
        logic [7:0]  txByte;
        logic        txAbort;
        logic        txStart;
        logic        txAckPayload;
        logic [3:0]  txPipe;
        logic        txForce0dbm;
        logic [6:0]  txChannel;
        logic        txReuse;
        logic        flushTx;
        logic        flushRx;
        logic        rxPop;
        logic [5:0]  rxPayloadIndex;
        logic        misoSync;
        logic        misoOe;
    } rscd_sys_t;

    rscd_rx_t  rx_reg, rx_next;
    rscd_tx_t  tx_reg, tx_next;
    rscd_sys_t sys_reg, sys_next;

    logic       byteDone;
    logic [7:0] byteIn;
    logic       evtValid;
    rscd_evt_t  evt;
    logic       dstValid;
    rscd_evt_t  dstEvt;
    logic       linkRst_b;
    logic       misoSynced;
    logic       oeSynced;

    function automatic logic isTxWrite(input logic [7:0] c);
        return c[7:5] == CMD_TX_WRITE_TOP;
    endfunction
    function automatic logic isAckWrite(input logic [7:0] c);
        return c[7:4] == CMD_ACK_WRITE_TOP;
    endfunction

    // chip select high holds rx_reg and tx_reg in reset (the cdc source toggle is not): new frame restarts decode
    assign linkRst_b = rst_b & ~chip_select_n;
    assign byteIn    = {rx_reg.shiftIn[6:0], spiMosi};
    assign byteDone  = rx_reg.bitCnt == 3'h7;

    always_comb
    begin
        rx_next  = rx_reg;
        evtValid = 1'b0;
        evt      = '0;
        rx_next.bitCnt  = rx_reg.bitCnt + 3'h1;
        rx_next.shiftIn = byteIn;
        if (byteDone && !rx_reg.dead)
        begin
            rx_next.count = rx_reg.count + 6'h1;
            unique case (rx_reg.phase)
                PH_CMD:
                begin
                    rx_next.cmd   = byteIn;
                    rx_next.count = '0;
                    rx_next.dead  = 1'b1;
                    evt.addr      = byteIn[5:0];
                    if (byteIn[7:6] == CMD_REG_RD_TOP)
                    begin
                        rx_next.phase = PH_REG_RD;
                        rx_next.dead  = 1'b0;
                    end
                    else if (byteIn[7:6] == CMD_REG_WR_TOP)
                    begin
                        rx_next.phase = PH_REG_WR;
                        rx_next.dead  = 1'b0;
                    end
                    else if (byteIn == CMD_RX_READ)
                    begin
                        rx_next.phase = PH_RX_HDR;
                        rx_next.dead  = 1'b0;
                    end
                    else if (isTxWrite(byteIn) || byteIn == CMD_REUSE_TX)
                    begin
                        rx_next.phase = PH_CHAN;
                        rx_next.dead  = 1'b0;
                    end
                    else if (isAckWrite(byteIn))
                    begin
                        rx_next.phase    = PH_TX_DATA;
                        rx_next.ackWrite = 1'b1;
                        rx_next.dead     = ~txBlockFree;
                        evtValid         = 1'b1;
                        evt.kind  = txBlockFree ? EV_TX_CHAN : EV_ABORT;
                        // addr bit 0 marks an ack payload start
                        evt.addr  = 6'h01;
                        evt.power0 = byteIn[ACK_POWER_BIT];
                        evt.pipe  = {1'b0, byteIn[2:0]} + 4'h1;
                    end
                    else if (byteIn == CMD_FLUSH_TX)
                    begin
                        evtValid = 1'b1;
                        evt.kind = EV_FLUSH_TX;
                    end
                    else if (byteIn == CMD_FLUSH_RX)
                    begin
                        evtValid = 1'b1;
                        evt.kind = EV_FLUSH_RX;
                    end
                    // status_only_cmd and unknown codes fall through idle
                end
                PH_REG_WR:
                begin
                    evtValid  = 1'b1;
                    evt.kind  = EV_REG_WR;
                    evt.addr  = rx_reg.cmd[5:0];
                    evt.data  = byteIn;
                    rx_next.dead = 1'b1;
                end
                PH_REG_RD:
                    rx_next.dead = 1'b1;
                PH_RX_HDR:
                begin
                    rx_next.phase  = PH_RX_LEN;
                    rx_next.length = rxPktLen;
                end
                PH_RX_LEN:
                begin
                    rx_next.phase = PH_RX_DATA;
                    rx_next.count = '0;
                end
                PH_RX_DATA:
                begin
                    evtValid     = 1'b1;
                    evt.kind     = EV_RX_POP;
                    evt.addr     = rx_reg.count;
                    rx_next.dead = rx_reg.count + 6'h1 == rx_reg.length;
                end
                PH_CHAN:
                begin
                    evtValid     = 1'b1;
                    evt.data     = {1'b0, byteIn[6:0]};
                    evt.power0   = rx_reg.cmd[TX_POWER_BIT];
                    evt.pipe     = rx_reg.cmd[3:0];
                    rx_next.count = '0;
                    if (rx_reg.cmd == CMD_REUSE_TX)
                    begin
                        evt.kind     = EV_REUSE;
                        rx_next.dead = 1'b1;
                    end
                    else
                    begin
                        rx_next.phase = PH_TX_DATA;
                        rx_next.dead  = ~txBlockFree || rx_reg.cmd[3:0] > PIPE_MAX;
                        evt.kind = rx_next.dead ? EV_ABORT : EV_TX_CHAN;
                    end
                end
                PH_TX_DATA:
                begin
                    evtValid = 1'b1;
                    evt.data = byteIn;
                    if (rx_reg.count >= 6'(PAYLOAD_BYTES))
                    begin
                        evt.kind     = EV_ABORT;
                        rx_next.dead = 1'b1;
                    end
                    else
                        evt.kind = EV_TX_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge spiSck or negedge linkRst_b)
    begin
        if (!linkRst_b)
            rx_reg <= '{phase: PH_CMD, default: '0};
        else
            rx_reg <= rx_next;
    end

    // output shifter on falling edge so data is stable at the next rise
    always_comb
    begin
        tx_next = tx_reg;
        tx_next.shiftOut = {tx_reg.shiftOut[6:0], 1'b0};
        if (rx_reg.bitCnt == 3'h0)
        begin
            tx_next.oe = ~rx_reg.dead || rx_reg.phase == PH_REG_RD;
            unique case (rx_reg.phase)
                PH_CMD:     tx_next.shiftOut = statusByte;
                PH_REG_RD:  tx_next.shiftOut = rx_reg.dead ? 8'h00 : regReadData;
                PH_RX_HDR:  tx_next.shiftOut = {rxPktRssi, rxPktPipe};
                PH_RX_LEN:  tx_next.shiftOut = {2'h0, rxPktLen};
                PH_RX_DATA: tx_next.shiftOut = rxPktByte;
                default:    tx_next.shiftOut = 8'h00;
            endcase
        end
    end

    always_ff @(negedge spiSck or negedge linkRst_b)
    begin
        if (!linkRst_b)
            tx_reg <= '0;
        else
            tx_reg <= tx_next;
    end

    // first status bit must be on the wire before the first rising edge
    logic misoRaw;
    assign misoRaw = (rx_reg.bitCnt == 3'h0 && rx_reg.phase == PH_CMD)
                   ? statusByte[7] : tx_reg.shiftOut[7];

    rscd_evt_cdc uCdc
    (
        .srcClock (spiSck),
        .srcRst_b (rst_b),
        .srcValid (evtValid),
        .srcEvt   (evt),
        .clock    (clock),
        .rst_b    (rst_b),
        .dstValid (dstValid),
        .dstEvt   (dstEvt)
    );
    rscd_sync uMiso
    (
        .clock (clock),
        .rst_b (rst_b),
        .dIn   (misoRaw),
        .dOut  (misoSynced)
    );
    rscd_sync uOe
    (
        .clock (clock),
        .rst_b (rst_b),
        .dIn   (~chip_select_n),
        .dOut  (oeSynced)
    );

    always_comb
    begin
        sys_next = sys_reg;
        sys_next.regWrite = 1'b0;
        sys_next.txPush   = 1'b0;
        sys_next.txAbort  = 1'b0;
        sys_next.txStart  = 1'b0;
        sys_next.txReuse  = 1'b0;
        sys_next.flushTx  = 1'b0;
        sys_next.flushRx  = 1'b0;
        sys_next.rxPop    = 1'b0;
        sys_next.misoSync = misoSynced;
        sys_next.misoOe   = oeSynced;
        if (dstValid)
        begin
            unique case (dstEvt.kind)
                EV_REG_WR:
                begin
                    sys_next.regWrite     = 1'b1;
                    sys_next.regAddr      = dstEvt.addr;
                    sys_next.regWriteData = dstEvt.data;
                end
                EV_TX_BYTE:
                begin
                    sys_next.txPush = 1'b1;
                    sys_next.txByte = dstEvt.data;
                end
                EV_TX_CHAN:
                begin
                    sys_next.txStart      = 1'b1;
                    sys_next.txAckPayload = dstEvt.addr[0];
                    sys_next.txPipe       = dstEvt.pipe;
                    sys_next.txForce0dbm  = dstEvt.power0;
                    sys_next.txChannel    = dstEvt.data[6:0];
                end
                EV_REUSE:
                begin
                    sys_next.txReuse     = 1'b1;
                    sys_next.txChannel   = dstEvt.data[6:0];
                end
                EV_FLUSH_TX: sys_next.flushTx = 1'b1;
                EV_FLUSH_RX: sys_next.flushRx = 1'b1;
                EV_ABORT:    sys_next.txAbort = 1'b1;
                EV_RX_POP:
                begin
                    sys_next.rxPop          = 1'b1;
                    sys_next.rxPayloadIndex = dstEvt.addr;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            sys_reg <= '0;
        else if (clockEnable)
            sys_reg <= sys_next;
    end

    assign regWrite       = sys_reg.regWrite;
    assign regAddr        = sys_reg.regAddr;
    assign regWriteData   = sys_reg.regWriteData;
    assign txPush         = sys_reg.txPush;
    assign txByte         = sys_reg.txByte;
    assign txAbort        = sys_reg.txAbort;
    assign txStart        = sys_reg.txStart;
    assign txAckPayload   = sys_reg.txAckPayload;
    assign txPipe         = sys_reg.txPipe;
    assign txForce0dbm    = sys_reg.txForce0dbm;
    assign txChannel      = sys_reg.txChannel;
    assign txReuse        = sys_reg.txReuse;
    assign flushTx        = sys_reg.flushTx;
    assign flushRx        = sys_reg.flushRx;
    assign rxPop          = sys_reg.rxPop;
    assign rxPayloadIndex = sys_reg.rxPayloadIndex;
    assign spiMiso        = sys_reg.misoSync;
    assign spiMisoOe      = sys_reg.misoOe;

    AST_FLUSH_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_b)
        flushTx |=> !flushTx) else $error("tx flush wider than one cycle");
    AST_REG_WR_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
        regWrite |=> !regWrite) else $error("register write repeated");
    AST_RX_LEN_BOUND: assert property (@(posedge clock) disable iff (!rst_b)
        rxPop |-> rxPayloadIndex < PAYLOAD_MAX) else $error("rx read past 32");
    AST_PIPE_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
        txStart |-> txPipe <= PIPE_MAX) else $error("pipe out of range");
    AST_NO_MIX: assert property (@(posedge clock) disable iff (!rst_b)
        !(txPush && (flushTx || flushRx || regWrite))) else $error("two actions at once");
    AST_REUSE_NO_PUSH: assert property (@(posedge clock) disable iff (!rst_b)
        txReuse |-> !txPush && !txStart) else $error("reuse pushed data");
    AST_ABORT_ALONE: assert property (@(posedge clock) disable iff (!rst_b)
        txAbort |-> !txPush) else $error("push on abort");
    AST_CHAN_HELD: assert property (@(posedge clock) disable iff (!rst_b)
        txPush |-> $stable(txChannel)) else $error("channel moved mid payload");
endmodule
`default_nettype wire

//--- rscd_host.sv
/*
 * rscd_host: spi master model sending whole mode 0 frames.
 * assumes: the bench fills frameQ before calling sendFrame.
 */
`timescale 1ns/1ps
`default_nettype none
module rscd_host
(
    // spi link
    output logic spiSck,
    output logic chip_select_n,
    output logic spiMosi
);
    logic [7:0] frameQ[$];
    initial
    begin
        spiSck = 1'b0;
        chip_select_n = 1'b1;
        spiMosi = 1'b0;
    end
    // sck runs only inside a frame, which ends on a byte boundary
    task automatic sendFrame();
        logic [7:0] b;
        chip_select_n = 1'b0;
        #31.7;
        while (frameQ.size() > 0)
        begin
            b = frameQ.pop_front();
            for (int i = 7; i >= 0; i--)
            begin
                spiMosi = b[i];
                #15;
                spiSck = 1'b1;
                #15;
                spiSck = 1'b0;
            end
        end
        #20;
        spiMosi = ~spiMosi;
        chip_select_n = 1'b1;
        #60;
    endtask
endmodule
`default_nettype wire

//--- test_radio_spi_command_decoder.sv
/*
 * test_radio_spi_command_decoder: frames from the host model, action
 * pulses compared with a queue model.
 * assumes: rscd_pkg, rscd_top and rscd_host are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL %0t got %h want %h", $time, a, b); end end
module test_radio_spi_command_decoder;
    import rscd_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, txBlockFree = 1'b1, spiSck, csN, spiMosi;
    logic [7:0] statusByte = 8'h02, regReadData = 8'h00;
    logic [3:0] rxPktRssi = 4'h5, rxPktPipe = 4'h2;
    logic [5:0] rxPktLen = 6'h01;
    logic [7:0] rxPktByte = 8'h3c;
    logic regWrite, txPush, txAbort, txStart, txReuse, flushTx, flushRx;
    logic txForce0dbm, txAckPayload, rxPop, spiMiso, spiMisoOe;
    logic [5:0] regAddr, rxPayloadIndex;
    logic [7:0] regWriteData, txByte;
    logic [3:0] txPipe;
    logic [6:0] txChannel;
    logic [31:0] expQ[$], obsQ[$];
    int err_total = 0, n_checks = 0;
    logic [31:0] seed = 32'd36;
    always #4 clock = ~clock;
    rscd_host u_host (.spiSck(spiSck), .chip_select_n(csN), .spiMosi(spiMosi));
    rscd_top #(.PAYLOAD_BYTES(4)) u_dut (.clock(clock), .rst_b(rst_b),
        .clockEnable(1'b1), .spiSck(spiSck), .chip_select_n(csN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .statusByte(statusByte), .regReadData(regReadData),
        .rxPktRssi(rxPktRssi), .rxPktPipe(rxPktPipe), .rxPktLen(rxPktLen),
        .rxPktByte(rxPktByte), .txBlockFree(txBlockFree), .regWrite(regWrite),
        .regAddr(regAddr), .regWriteData(regWriteData), .txPush(txPush),
        .txByte(txByte), .txAbort(txAbort), .txStart(txStart),
        .txAckPayload(txAckPayload), .txPipe(txPipe),
        .txForce0dbm(txForce0dbm), .txChannel(txChannel),
        .txReuse(txReuse), .flushTx(flushTx), .flushRx(flushRx),
        .rxPop(rxPop), .rxPayloadIndex(rxPayloadIndex));
    // observed actions, one word each: kind, then fields
    always @(posedge clock)
    begin
        if (regWrite === 1'b1) obsQ.push_back({8'h1, 2'h0, regAddr, regWriteData, 8'h0});
        if (txPush === 1'b1) obsQ.push_back({8'h2, txByte, 16'h0});
        if (txStart === 1'b1) obsQ.push_back({8'h3, 4'h0, txPipe, 7'h0, txForce0dbm, txAckPayload, txChannel});
        if (rxPop === 1'b1) obsQ.push_back({8'h8, 2'h0, rxPayloadIndex, 16'h0});
        if (txReuse === 1'b1) obsQ.push_back({8'h4, 17'h0, txChannel});
        if (flushTx === 1'b1) obsQ.push_back(32'h05000000);
        if (flushRx === 1'b1) obsQ.push_back(32'h06000000);
        if (txAbort === 1'b1) obsQ.push_back(32'h07000000);
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic put(input logic [7:0] b);
        u_host.frameQ.push_back(b);
    endtask
    // send the frame, let actions cross, compare in order
    task automatic run(input string name);
        u_host.sendFrame();
        repeat (40) @(posedge clock);
        `CHK(obsQ.size(), expQ.size())
        while (expQ.size() > 0 && obsQ.size() > 0)
            `CHK(obsQ.pop_front(), expQ.pop_front())
        `CHK(spiMisoOe, 1'b0)
        obsQ.delete();
        expQ.delete();
        $display("done %s", name);
    endtask
    task automatic txFrame(input logic [7:0] cmd, input logic [3:0] pipe,
        input int n, input bit ack);
        logic [7:0] ch, d;
        ch = rnd() & 8'h7f;
        put(cmd);
        if (!ack)
            put(ch);
        expQ.push_back({8'h3, 4'h0, pipe, 7'h0, cmd[ack ? 3 : 4], ack,
            ack ? 7'h0 : ch[6:0]});
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            put(d);
            if (i < 4)
                expQ.push_back({8'h2, d, 16'h0});
        end
        if (n > 4)
            expQ.push_back(32'h07000000);
    endtask
    initial
    begin
        logic [7:0] a, d;
        #300_000;
        err_total++;
        $display("FAIL %0t watchdog expired", $time);
        end_sim();
    end
    initial
    begin
        logic [7:0] a, d;
        repeat (3) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 4; i++)
        begin
            a = rnd() & 8'h3f;
            d = rnd();
            statusByte = rnd();
            regReadData = rnd();
            put(8'h40 | a);
            put(d);
            expQ.push_back({8'h1, a, d, 8'h0});
            run("reg write");
            put(a);
            put(8'h00);
            run("reg read");
        end
        put(STATUS_ONLY_CMD);
        run("status only");
        for (int p = 0; p < 9; p++)
        begin
            txFrame(8'ha0 | 8'(p) | 8'((p % 2) << 4), 4'(p), 1 + p % 4, 1'b0);
            run("tx write");
        end
        for (int p = 0; p < 8; p++)
        begin
            txFrame(8'he0 | 8'(p) | 8'((p % 2) << 3), 4'(p + 1), 2, 1'b1);
            run("ack write");
        end
        d = rnd() & 8'h7f;
        put(CMD_REUSE_TX);
        put(d);
        expQ.push_back({8'h4, 16'h0, d});
        run("reuse");
        put(CMD_FLUSH_TX);
        expQ.push_back(32'h05000000);
        run("flush tx");
        put(CMD_FLUSH_RX);
        expQ.push_back(32'h06000000);
        run("flush rx");
        #1 rxPktLen = 6'h02;
        rxPktByte = rnd();
        rxPktRssi = 4'ha;
        rxPktPipe = 4'h7;
        put(CMD_RX_READ);
        repeat (4) put(8'hff);
        expQ.push_back({8'h8, 2'h0, 6'h00, 16'h0});
        expQ.push_back({8'h8, 2'h0, 6'h01, 16'h0});
        run("rx read");
        txFrame(8'ha3, 4'h3, 5, 1'b0);
        run("oversize");
        @(posedge clock);
        #1 txBlockFree = 1'b0;
        put(8'ha1);
        put(8'h11);
        put(8'h22);
        expQ.push_back(32'h07000000);
        run("no block");
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire
